// *** hdl/tad_pkg.sv ***
package tad_pkg;

  // register indices; the byte address is four times the index
  localparam logic [11:0] TAD_IDX_RUN     = 12'h320;
  localparam logic [11:0] TAD_IDX_ONESHOT = 12'h322;
  localparam logic [11:0] TAD_IDX_TRGSEL  = 12'h323;
  localparam logic [11:0] TAD_IDX_DIR     = 12'h324;

  // count start flags
  localparam int TAD_RUN_CH3 = 3;
  localparam int TAD_RUN_CH4 = 4;
  // count direction and two-phase enables
  localparam int TAD_DIR_CH3 = 3;
  localparam int TAD_DIR_CH4 = 4;
  localparam int TAD_TP_CH3  = 6;
  localparam int TAD_TP_CH4  = 7;
  // one-shot start, index enable and channel 0 source
  localparam int TAD_OS_CH3  = 3;
  localparam int TAD_OS_CH4  = 4;
  localparam int TAD_ZEN     = 5;
  localparam int TAD_SEL0_LO = 6;
  // trigger select fields for channels 2, 3 and 4
  localparam int TAD_SEL2_LO = 2;
  localparam int TAD_SEL3_LO = 4;
  localparam int TAD_SEL4_LO = 6;

  // writable bits of each register, everything else reads zero
  localparam logic [7:0] TAD_RUN_MASK = 8'h18;
  localparam logic [7:0] TAD_OS_MASK  = 8'hE0;
  localparam logic [7:0] TAD_TRG_MASK = 8'hFC;
  localparam logic [7:0] TAD_DIR_MASK = 8'hD8;

  // values after reset
  localparam logic [7:0] TAD_RST_VAL  = 8'h00;
  localparam logic       TAD_WAIT_RST = 1'b1;

  // byte address of a register index
  function automatic logic [13:0] tad_byte_addr(input logic [11:0] idx);
    tad_byte_addr = {idx, 2'b00};
  endfunction : tad_byte_addr

endpackage : tad_pkg

// *** hdl/tad_src_mux.sv ***
`timescale 1ns/1ps
// registered four-way event source picker for one timer channel
module tad_src_mux (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       ce_i,
  input  wire logic [1:0] sel_i,
  input  wire logic [3:0] src_i,
  output logic            evt_o
);

  logic evt_d;
  logic evt_q;

  // code 00 pin, 01 timer b ch2, 10/11 per-channel sibling
  always_comb begin
    evt_d = src_i[sel_i]; // [RULE_05] [RULE_06] [RULE_07] [RULE_08]
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      evt_q <= 1'b0;
    end else if (ce_i) begin
      evt_q <= evt_d;
    end
  end

  assign evt_o = evt_q;

  property p_src_pick;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      ce_i |=> evt_o == $past(src_i[sel_i]);
  endproperty
  a_src_pick: assert property (p_src_pick) // [RULE_05] [RULE_06]
    else $error("event source pick wrong");

endmodule : tad_src_mux

// *** hdl/tad_ctrl.sv ***
`timescale 1ns/1ps
// How it works
// RULE_01 - direction bits 3 and 4 for channels 3 and 4: 0 down, 1 up.
// RULE_02 - bits 6 and 7 enable two-phase counting on channels 3 and 4.
// RULE_03 - writing 1 to one-shot bits 3/4 starts that channel; reads 0.
// RULE_04 - one-shot register bit 5 gates the index input to the counter.
// RULE_05 - one-shot bits 7-6 pick channel 0 source: pin, b2, a4, a1.
// RULE_06 - trigger bits 3-2 pick channel 2 source: pin, b2, a1, a3.
// RULE_07 - trigger bits 5-4 pick channel 3 source: pin, b2, a2, a4.
// RULE_08 - trigger bits 7-6 pick channel 4 source: pin, b2, a3, a0.
// RULE_09 - software clears mode switching bit so direction comes from here.
// RULE_10 - count start bits 3 and 4: 1 starts, 0 stops channels 3 and 4.
// RULE_11 - direction bit used only while two-phase counting is off.
// RULE_12 - one-shot start accepted in one-shot mode, fires on next edge.
module tad_ctrl
  import tad_pkg::*;
#(
  parameter int ADDR_W = 14
) (
  input  wire logic              ref_clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              ce_i,
  input  wire logic [ADDR_W-1:0] avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output logic      [31:0]       avs_readdata_o,
  output logic                   avs_waitrequest_o,
  input  wire logic [1:0]        oneshot_mode_i,
  input  wire logic [1:0]        count_edge_i,
  input  wire logic [1:0]        phase_dir_i,
  input  wire logic              z_phase_i,
  input  wire logic              timer_a_ch0_input_pin_i,
  input  wire logic              timer_a_ch2_input_pin_i,
  input  wire logic              timer_a_ch3_input_pin_i,
  input  wire logic              timer_a_ch4_input_pin_i,
  input  wire logic              timer_b_ch2_i,
  input  wire logic [4:0]        timer_a_evt_i,
  output logic      [1:0]        count_up_o,
  output logic      [1:0]        two_phase_en_o,
  output logic      [1:0]        count_run_o,
  output logic      [1:0]        oneshot_start_o,
  output logic                   z_phase_o,
  output logic                   trig_ch0_o,
  output logic                   trig_ch2_o,
  output logic                   trig_ch3_o,
  output logic                   trig_ch4_o
);

  logic        wait_d, wait_q;
  logic [31:0] rdata_d, rdata_q;
  logic [7:0]  run_d, run_q;
  logic [7:0]  os_d, os_q;
  logic [7:0]  trg_d, trg_q;
  logic [7:0]  dir_d, dir_q;
  logic [1:0]  pend_d, pend_q;
  logic [1:0]  start_d, start_q;
  logic [1:0]  up_d, up_q;
  logic        z_d, z_q;
  logic        req;
  logic        done;
  logic        lane0;
  logic        hit_run, hit_os, hit_trg, hit_dir;
  logic [1:0]  os_wr_bits;

  // address decode of the four byte registers
  always_comb begin
    req     = avs_read_i | avs_write_i;
    done    = req & ~wait_q;
    lane0   = avs_byteenable_i[0];
    hit_run = 1'b0;
    hit_os  = 1'b0;
    hit_trg = 1'b0;
    hit_dir = 1'b0;
    if (avs_address_i == tad_byte_addr(TAD_IDX_RUN)) begin
      hit_run = 1'b1;
    end else if (avs_address_i == tad_byte_addr(TAD_IDX_ONESHOT)) begin
      hit_os = 1'b1;
    end else if (avs_address_i == tad_byte_addr(TAD_IDX_TRGSEL)) begin
      hit_trg = 1'b1;
    end else if (avs_address_i == tad_byte_addr(TAD_IDX_DIR)) begin
      hit_dir = 1'b1;
    end
  end

  // one wait cycle per access: read data is settled before the release
  always_comb begin
    wait_d  = ~(req & wait_q);
    rdata_d = rdata_q;
    if (req & wait_q & avs_read_i) begin
      rdata_d = 32'h0000_0000; // unmapped or reserved reads as zero
      if (hit_run) begin
        rdata_d[7:0] = run_q;
      end else if (hit_os) begin
        rdata_d[7:0] = os_q; // start bits are never stored [RULE_03]
      end else if (hit_trg) begin
        rdata_d[7:0] = trg_q;
      end else if (hit_dir) begin
        rdata_d[7:0] = dir_q;
      end
    end
  end

  // register writes take effect at the edge with waitrequest low
  always_comb begin
    run_d      = run_q;
    os_d       = os_q;
    trg_d      = trg_q;
    dir_d      = dir_q;
    os_wr_bits = 2'b00;
    if (done & avs_write_i & lane0) begin
      if (hit_run) begin
        run_d = avs_writedata_i[7:0] & TAD_RUN_MASK; // [RULE_10]
      end else if (hit_os) begin
        os_d = avs_writedata_i[7:0] & TAD_OS_MASK; // [RULE_04] [RULE_05]
        os_wr_bits = {avs_writedata_i[TAD_OS_CH4],
                      avs_writedata_i[TAD_OS_CH3]}; // [RULE_03]
      end else if (hit_trg) begin
        trg_d = avs_writedata_i[7:0] & TAD_TRG_MASK; // [RULE_06]
      end else if (hit_dir) begin
        dir_d = avs_writedata_i[7:0] & TAD_DIR_MASK; // [RULE_01] [RULE_02]
      end
    end
  end

  // one-shot pending: a fresh request beats the edge that would clear it;
  // leaving one-shot mode drops a request that was never honoured
  always_comb begin
    pend_d  = ((pend_q & ~count_edge_i) | os_wr_bits)
              & oneshot_mode_i; // [RULE_12]
    start_d = pend_q & count_edge_i & oneshot_mode_i; // [RULE_03] [RULE_12]
  end

  // direction: two-phase phase detector wins over the software bit;
  // the mode register must select this register as source [RULE_09]
  always_comb begin
    up_d[0] = dir_q[TAD_TP_CH3] ? phase_dir_i[0]
                                : dir_q[TAD_DIR_CH3]; // [RULE_01] [RULE_11]
    up_d[1] = dir_q[TAD_TP_CH4] ? phase_dir_i[1]
                                : dir_q[TAD_DIR_CH4]; // [RULE_01] [RULE_11]
    z_d     = z_phase_i & os_q[TAD_ZEN]; // [RULE_04]
  end

  // all state frozen while the clock enable is low
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_q  <= TAD_WAIT_RST;
      rdata_q <= 32'h0000_0000;
      run_q   <= TAD_RST_VAL;
      os_q    <= TAD_RST_VAL;
      trg_q   <= TAD_RST_VAL;
      dir_q   <= TAD_RST_VAL;
      pend_q  <= 2'b00;
      start_q <= 2'b00;
      up_q    <= 2'b00;
      z_q     <= 1'b0;
    end else if (ce_i) begin
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
      run_q   <= run_d;
      os_q    <= os_d;
      trg_q   <= trg_d;
      dir_q   <= dir_d;
      pend_q  <= pend_d;
      start_q <= start_d;
      up_q    <= up_d;
      z_q     <= z_d;
    end
  end

  assign avs_waitrequest_o = wait_q;
  assign avs_readdata_o    = rdata_q;
  assign count_run_o       = {run_q[TAD_RUN_CH4], run_q[TAD_RUN_CH3]};
  assign two_phase_en_o    = {dir_q[TAD_TP_CH4], dir_q[TAD_TP_CH3]};
  assign count_up_o        = up_q;
  assign oneshot_start_o   = start_q;
  assign z_phase_o         = z_q;

  // event source pickers, source order pin, b2, then the two siblings
  tad_src_mux u_sel_ch0 (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .sel_i     (os_q[TAD_SEL0_LO +: 2]),
    .src_i     ({timer_a_evt_i[1], timer_a_evt_i[4], timer_b_ch2_i,
                 timer_a_ch0_input_pin_i}), // [RULE_05]
    .evt_o     (trig_ch0_o)
  );
  tad_src_mux u_sel_ch2 (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .sel_i     (trg_q[TAD_SEL2_LO +: 2]),
    .src_i     ({timer_a_evt_i[3], timer_a_evt_i[1], timer_b_ch2_i,
                 timer_a_ch2_input_pin_i}), // [RULE_06]
    .evt_o     (trig_ch2_o)
  );
  tad_src_mux u_sel_ch3 (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .sel_i     (trg_q[TAD_SEL3_LO +: 2]),
    .src_i     ({timer_a_evt_i[4], timer_a_evt_i[2], timer_b_ch2_i,
                 timer_a_ch3_input_pin_i}), // [RULE_07]
    .evt_o     (trig_ch3_o)
  );
  tad_src_mux u_sel_ch4 (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .sel_i     (trg_q[TAD_SEL4_LO +: 2]),
    .src_i     ({timer_a_evt_i[0], timer_a_evt_i[3], timer_b_ch2_i,
                 timer_a_ch4_input_pin_i}), // [RULE_08]
    .evt_o     (trig_ch4_o)
  );

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_wr(logic hit);
    ce_i && avs_write_i && !avs_waitrequest_o && lane0 && hit;
  endsequence
  sequence s_rd(logic hit);
    ce_i && avs_read_i && !avs_waitrequest_o && hit;
  endsequence

  property p_dir_bits;
    (s_wr(hit_dir) ##0 !avs_writedata_i[TAD_TP_CH3]) ##1 ce_i
      |=> count_up_o[0] == $past(avs_writedata_i[TAD_DIR_CH3], 2);
  endproperty
  a_dir_bits: assert property (p_dir_bits) // [RULE_01]
    else $error("channel 3 direction not from register");

  property p_two_phase;
    s_wr(hit_dir) |=> two_phase_en_o ==
      {$past(avs_writedata_i[TAD_TP_CH4]), $past(avs_writedata_i[TAD_TP_CH3])};
  endproperty
  a_two_phase: assert property (p_two_phase) // [RULE_02]
    else $error("two-phase enables not stored");

  property p_os_read_zero;
    s_rd(hit_os) |-> avs_readdata_o[TAD_OS_CH4:TAD_OS_CH3] == 2'b00;
  endproperty
  a_os_read_zero: assert property (p_os_read_zero) // [RULE_03]
    else $error("one-shot start bits read nonzero");

  property p_zgate;
    ce_i |=> z_phase_o == ($past(z_phase_i) && $past(os_q[TAD_ZEN]));
  endproperty
  a_zgate: assert property (p_zgate) // [RULE_04]
    else $error("index input gating wrong");

  property p_run_flags;
    s_wr(hit_run) |=> count_run_o ==
      {$past(avs_writedata_i[TAD_RUN_CH4]), $past(avs_writedata_i[TAD_RUN_CH3])};
  endproperty
  a_run_flags: assert property (p_run_flags) // [RULE_10]
    else $error("count start flags not stored");

  property p_phase_dir;
    ce_i && two_phase_en_o[1] |=> count_up_o[1] == $past(phase_dir_i[1]);
  endproperty
  a_phase_dir: assert property (p_phase_dir) // [RULE_11]
    else $error("two-phase direction ignored");

  property p_os_fire;
    (s_wr(hit_os) ##0 (avs_writedata_i[TAD_OS_CH3] && oneshot_mode_i[0]))
      ##1 (ce_i && oneshot_mode_i[0] && count_edge_i[0])
      |=> oneshot_start_o[0];
  endproperty
  a_os_fire: assert property (p_os_fire) // [RULE_12]
    else $error("one-shot start not issued on edge");

  property p_os_mode;
    ce_i && !oneshot_mode_i[1] |=> !oneshot_start_o[1];
  endproperty
  a_os_mode: assert property (p_os_mode) // [RULE_12]
    else $error("one-shot start outside one-shot mode");

  property p_bus_wait;
    ce_i && (avs_read_i || avs_write_i) && avs_waitrequest_o
      |=> !avs_waitrequest_o;
  endproperty
  a_bus_wait: assert property (p_bus_wait)
    else $error("waitrequest not released");

endmodule : tad_ctrl

// *** verif/tad_far_model.sv ***
`timescale 1ns/1ps
// far side: input pins, sibling timers, phase detector and index line
module tad_far_model (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [15:0] rnd_i,
  output logic      [3:0]  pin_o,
  output logic             tb2_o,
  output logic      [4:0]  ta_evt_o,
  output logic      [1:0]  phase_dir_o,
  output logic             z_o
);
  // fresh levels every cycle, so a stale source passes for a match only by chance
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {pin_o, tb2_o, ta_evt_o, phase_dir_o, z_o} <= '0;
    end else begin
      {pin_o, tb2_o, ta_evt_o, phase_dir_o, z_o} <= rnd_i[12:0];
    end
  end
endmodule : tad_far_model

// *** verif/tb_timer_a_trigger_direction_ctrl.sv ***
`timescale 1ns/1ps
module tb_timer_a_trigger_direction_ctrl;
  import tad_pkg::*;
  localparam logic [13:0] A_RN = {TAD_IDX_RUN, 2'b00};
  localparam logic [13:0] A_OS = {TAD_IDX_ONESHOT, 2'b00};
  localparam logic [13:0] A_TR = {TAD_IDX_TRGSEL, 2'b00};
  localparam logic [13:0] A_DR = {TAD_IDX_DIR, 2'b00};
  logic        ref_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [13:0] adr = '0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = '0;
  logic [31:0] rdata;
  logic [3:0]  be = 4'hF;
  logic        ce = 1'b1;
  logic [6:0]  hold;
  logic [13:0] ra [5] = '{A_RN, A_OS, A_TR, A_DR, A_RN + 14'h4};
  logic        wt, tb2, z, zo;
  logic [1:0]  osm = '0;
  logic [1:0]  edg = '0;
  logic [1:0]  up, tpe, run, oss, pd;
  logic [3:0]  pin, trg;
  logic [4:0]  ta;
  logic [31:0] x = 32'd18424;
  logic [31:0] r;
  logic [7:0]  o_sh, t_sh, d_sh;
  logic [7:0]  q[$];
  int          mismatches = 0;
  int          n_compared = 0;
  int          cyc = 0;

  tad_ctrl u_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(ce),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wt), .oneshot_mode_i(osm), .count_edge_i(edg),
    .phase_dir_i(pd), .z_phase_i(z), .timer_a_ch0_input_pin_i(pin[0]),
    .timer_a_ch2_input_pin_i(pin[1]), .timer_a_ch3_input_pin_i(pin[2]),
    .timer_a_ch4_input_pin_i(pin[3]), .timer_b_ch2_i(tb2),
    .timer_a_evt_i(ta), .count_up_o(up), .two_phase_en_o(tpe),
    .count_run_o(run), .oneshot_start_o(oss), .z_phase_o(zo),
    .trig_ch0_o(trg[0]), .trig_ch2_o(trg[1]), .trig_ch3_o(trg[2]),
    .trig_ch4_o(trg[3]));

  tad_far_model u_far (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .rnd_i(x[15:0]), .pin_o(pin), .tb2_o(tb2), .ta_evt_o(ta),
    .phase_dir_o(pd), .z_o(z));

  // clock, random source and hang guard
  always #12.5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    x <= xs(x);
    cyc++;
    if (cyc > 3000) begin
      mismatches++;
      final_report();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs

  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one bus cycle; held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [13:0] a,
                     input logic [7:0] d, input logic [7:0] e);
    @(posedge ref_clk_i);
    adr <= a;
    wd  <= {24'h0, d};
    rd  <= !w;
    wr  <= w;
    if (!w) q.push_back(e);
    do @(posedge ref_clk_i); while (wt !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  // read answers leave the queue in issue order
  always @(posedge ref_clk_i) begin
    if (rd && wt === 1'b0) begin
      chk("readdata", rdata[7:0], q.pop_front());
    end
  end

  // sources seen one cycle, selected copy expected the next
  // direction comes from this block, mode switch bit kept clear
  task automatic smp(input int n);
    logic [3:0] p, e;
    logic [4:0] a;
    logic [1:0] ph;
    logic       b, zz;
    repeat (n) begin
      @(posedge ref_clk_i);
      #1;
      {p, b, a, ph, zz} = {pin, tb2, ta, pd, z};
      e[0] = 1'({a[1], a[4], b, p[0]} >> o_sh[7:6]);
      e[1] = 1'({a[3], a[1], b, p[1]} >> t_sh[3:2]);
      e[2] = 1'({a[4], a[2], b, p[2]} >> t_sh[5:4]);
      e[3] = 1'({a[0], a[3], b, p[3]} >> t_sh[7:6]);
      @(posedge ref_clk_i);
      #1;
      chk("trig", {4'h0, trg}, {4'h0, e});
      chk("up_z", {5'h0, zo, up}, {5'h0, zz & o_sh[5],
        d_sh[7] ? ph[1] : d_sh[4], d_sh[6] ? ph[0] : d_sh[3]});
    end
  endtask : smp

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  // reset values, register masks, every select code, one-shot starts
  initial begin
    repeat (12) @(posedge ref_clk_i);
    chk("wait_rst", {7'h0, wt}, 8'h01);
    rst_n_i <= 1'b1;
    foreach (ra[k]) begin
      bus(0, ra[k], 8'h00, 8'h00);
    end
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      r = x;
      o_sh = {i[1:0], r[5:0]} & TAD_OS_MASK;
      t_sh = {i[1:0], i[1:0], i[1:0], r[7:6]} & TAD_TRG_MASK;
      d_sh = r[15:8] & TAD_DIR_MASK;
      bus(1, A_OS, {i[1:0], r[5:0]}, 8'h00);
      bus(1, A_TR, {i[1:0], i[1:0], i[1:0], r[7:6]}, 8'h00);
      bus(1, A_DR, r[15:8], 8'h00);
      bus(1, A_RN, r[23:16], 8'h00);
      bus(0, A_OS, 8'h00, o_sh);
      bus(0, A_TR, 8'h00, t_sh);
      bus(0, A_DR, 8'h00, d_sh);
      bus(0, A_RN, 8'h00, r[23:16] & TAD_RUN_MASK);
      chk("run", {6'h0, run}, {6'h0, r[20], r[19]});
      chk("two_phase", {6'h0, tpe}, {6'h0, d_sh[7:6]});
      smp(6);
    end
    be <= 4'h0;
    bus(1, A_DR, 8'hFF, 8'h00);
    be <= 4'hF;
    bus(1, A_RN + 14'h4, 8'hFF, 8'h00);
    bus(0, A_RN + 14'h4, 8'h00, 8'h00);
    bus(0, A_DR, 8'h00, d_sh);
    // clock enable low: outputs hold while the far side keeps moving
    @(posedge ref_clk_i);
    ce <= 1'b0;
    #1;
    hold = {zo, up, trg};
    repeat (4) @(posedge ref_clk_i);
    #1;
    chk("freeze", {1'b0, zo, up, trg}, {1'b0, hold});
    @(posedge ref_clk_i);
    ce <= 1'b1;
    $display("test registers and selects done");
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk_i);
      osm <= {2{k[1]}};
      bus(1, A_OS, o_sh | (8'h08 << k[0]), 8'h00);
      edg <= 2'b11;
      @(posedge ref_clk_i);
      edg <= 2'b00;
      #1;
      chk("os_start", {6'h0, oss}, {6'h0, k[1] ? 2'(1 << k[0]) : 2'b00});
      @(posedge ref_clk_i);
      #1;
      chk("os_end", {6'h0, oss}, 8'h00);
    end
    bus(0, A_OS, 8'h00, o_sh);
    repeat (3) @(posedge ref_clk_i);
    $display("test one-shot done");
    final_report();
  end
endmodule : tb_timer_a_trigger_direction_ctrl
